// *** sao_pkg.sv ***
package sao_pkg;

	// ------------------------------------------------------------
	// Sample and word layout
	// ------------------------------------------------------------
	localparam int         SAMPLE_W      = 24;
	localparam int         WORD_W        = 64;
	localparam logic [1:0] RES_24        = 2'h0;
	localparam logic [1:0] RES_20        = 2'h1;
	localparam logic [1:0] RES_16        = 2'h2;
	localparam logic [1:0] RES_AES3      = 2'h3;
	localparam logic [4:0] BITS_24       = 5'h18;
	localparam logic [4:0] BITS_20       = 5'h14;
	localparam logic [4:0] BITS_16       = 5'h10;

	// ------------------------------------------------------------
	// Frame and clock timing
	// ------------------------------------------------------------
	localparam logic [6:0] HALF_LAST_32  = 7'h1f;
	localparam logic [6:0] HALF_LAST_64  = 7'h3f;
	localparam logic [6:0] IDX_MAX       = 7'h7f;
	localparam logic [3:0] BCLK_HALF_CYC = 4'h2;
	localparam logic [1:0] SLIP_CNT_MAX  = 2'h2;

	// ------------------------------------------------------------
	// Types and reset values
	// ------------------------------------------------------------
	typedef struct packed {
		logic [23:0] data;
		logic        v;
		logic        u;
		logic        c;
		logic        z;
	} subframe_t;

	localparam subframe_t SUBFRAME_RST = 28'h0;

	// Number of audio bits kept for a resolution code
	function automatic logic [4:0] res_bits(input logic [1:0] res);
		unique case (res)
			RES_20:  res_bits = BITS_20;
			RES_16:  res_bits = BITS_16;
			default: res_bits = BITS_24;
		endcase
	endfunction : res_bits

endpackage : sao_pkg

// *** sao_fmt_if.sv ***
`timescale 1ns/10ps
interface sao_fmt_if;
	sao_pkg::subframe_t sub;
	logic [1:0]         res;
	logic               justify;
	logic               half64;
	logic [63:0]        word;

	modport fmt  (input sub, input res, input justify, input half64, output word);
	modport user (output sub, output res, output justify, output half64, input word);
endinterface : sao_fmt_if

// *** sao_word_formatter.sv ***
`timescale 1ns/10ps
module sao_word_formatter (
	sao_fmt_if.fmt f
);

	// ------------------------------------------------------------
	// Subframe word builder, msb first from bit 63
	// ------------------------------------------------------------
	logic [4:0]         nbits;
	logic [23:0]        keep_mask;
	logic signed [23:0] trunc;
	logic [63:0]        sext;

	// Resolution only trims the output; the received 24 bits are never cut by word length fields
	always_comb begin
		nbits     = sao_pkg::res_bits(f.res);
		keep_mask = ~((24'h1 << (sao_pkg::BITS_24 - nbits)) - 24'h1);
		trunc     = $signed(f.sub.data) >>> (sao_pkg::BITS_24 - nbits);
		sext      = 64'(trunc);
		if (f.res == sao_pkg::RES_AES3) begin
			f.word = {f.sub.data, f.sub.v, f.sub.u, f.sub.c, f.sub.z, 36'h0};
		end else if (f.justify) begin
			// Bits ahead of the msb copy the msb, so the half-frame length sets the alignment
			f.word = f.half64 ? sext : {sext[31:0], 32'h0};
		end else begin
			f.word = {f.sub.data & keep_mask, 40'h0};
		end
	end

endmodule : sao_word_formatter

// *** serial_audio_output_port.sv ***
// Overview of operation
// - Software selects master/slave, bit rate, resolution, justify, delay and clock polarities.
// - Right-justified words fill all bits before the msb with copies of it.
// - AES3 direct format carries the received V, U and C bits.
// - AES3 direct parity slot carries Z, set on the subframe before block start.
// - Block start pin is driven only in hardware mode.
// - Master mode drives word and bit clocks, derived from the master clock.
// - Slave mode flags a repeated or dropped left output sample.
// - Mute bit silences the serial data at once.
// - Control encodings select left-justified, I2S, right-justified and AES3 direct.
// - All 24 received audio bits are stored, unaffected by word length fields; resolution trims only the output.
`timescale 1ns/10ps
module serial_audio_output_port (
	input  wire logic        CLOCK_IN,
	input  wire logic        NRST_IN,
	input  wire logic        CLOCK_EN_IN,
	input  wire logic        PORT_MASTER_SELECT_IN,
	input  wire logic        BIT_CLOCK_RATE_SELECT_IN,
	input  wire logic [1:0]  RESOLUTION_FIELD_IN,
	input  wire logic        JUSTIFY_SELECT_IN,
	input  wire logic        FIRST_BIT_DELAY_IN,
	input  wire logic        BIT_CLOCK_POLARITY_IN,
	input  wire logic        WORD_CLOCK_POLARITY_IN,
	input  wire logic        OUTPUT_MUTE_BIT_IN,
	input  wire logic        HARDWARE_MODE_IN,
	input  wire logic        SLIP_CLEAR_IN,
	input  wire logic        SAMPLE_VALID_IN,
	input  wire logic        SAMPLE_RIGHT_IN,
	input  wire logic [23:0] SAMPLE_DATA_IN,
	input  wire logic        SAMPLE_V_IN,
	input  wire logic        SAMPLE_U_IN,
	input  wire logic        SAMPLE_C_IN,
	input  wire logic        BLOCK_START_IN,
	input  wire logic        OUT_BIT_CLOCK_IN,
	output logic             OUT_BIT_CLOCK_OUT,
	output logic             OUT_BIT_CLOCK_OE_OUT,
	input  wire logic        OUT_WORD_CLOCK_IN,
	output logic             OUT_WORD_CLOCK_OUT,
	output logic             OUT_WORD_CLOCK_OE_OUT,
	output logic             SERIAL_DATA_OUT,
	output logic             SAMPLE_SLIP_FLAG_OUT,
	output logic             BLOCK_START_PIN_OUT
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [3:0]          div_cnt_ff;
	logic                mbclk_ff;
	logic                mwclk_ff;
	logic                sbclk_ff;
	logic                sbclk_prev_ff;
	logic                swclk_ff;
	logic                swclk_prev_ff;
	logic [6:0]          idx_ff;
	logic [63:0]         word_ff;
	logic                raw_bit_ff;
	logic                sdo_ff;
	sao_pkg::subframe_t  pend_ff;
	logic                pend_right_ff;
	logic                pend_vld_ff;
	sao_pkg::subframe_t  hold_ff [2];
	logic [1:0]          left_cnt_ff;
	logic                slip_ff;
	logic                blk_pin_ff;

	logic                m_tick;
	logic                m_inact;
	logic                inact_edge;
	logic                half_start;
	logic                new_wc;
	logic                new_left;
	logic [6:0]          half_last;
	logic [6:0]          pos;
	logic                nxt_raw_bit;
	logic                commit;
	logic                commit_left;

	sao_fmt_if fif ();

	sao_word_formatter u_fmt (
		.f (fif.fmt)
	);

	// ------------------------------------------------------------
	// Bit and word clock generation and edge detection
	// ------------------------------------------------------------

	// Master timing events; the inactive edge is the one whose new level equals the polarity bit
	always_comb begin
		m_tick     = (div_cnt_ff == sao_pkg::BCLK_HALF_CYC - 4'h1);
		m_inact    = m_tick && ((~mbclk_ff) == BIT_CLOCK_POLARITY_IN);
		half_last  = BIT_CLOCK_RATE_SELECT_IN ? sao_pkg::HALF_LAST_64 : sao_pkg::HALF_LAST_32;
		if (PORT_MASTER_SELECT_IN) begin
			inact_edge = m_inact;
			half_start = m_inact && (idx_ff >= half_last);
			new_wc     = ~mwclk_ff;
		end else begin
			// Slave pins are taken as synchronous; a stopped bit clock just yields no edges
			inact_edge = (sbclk_ff != sbclk_prev_ff) && (sbclk_ff == BIT_CLOCK_POLARITY_IN);
			half_start = (swclk_ff != swclk_prev_ff);
			new_wc     = swclk_ff;
		end
		new_left = new_wc ^ WORD_CLOCK_POLARITY_IN;
	end

	// Master divider keeps running in slave mode, so a mode switch starts on a clean phase
	always_ff @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			div_cnt_ff <= 4'h0;
			mbclk_ff   <= 1'b0;
		end else if (CLOCK_EN_IN) begin
			div_cnt_ff <= m_tick ? 4'h0 : div_cnt_ff + 4'h1;
			if (m_tick) begin
				mbclk_ff <= ~mbclk_ff;
			end
		end
	end

	// Word clock toggles on the inactive edge ending the last bit of a half frame
	always_ff @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			mwclk_ff <= 1'b0;
		end else if (CLOCK_EN_IN && PORT_MASTER_SELECT_IN && half_start) begin
			mwclk_ff <= ~mwclk_ff;
		end
	end

	// Slave pin sampling
	always_ff @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			sbclk_ff      <= 1'b0;
			sbclk_prev_ff <= 1'b0;
			swclk_ff      <= 1'b0;
			swclk_prev_ff <= 1'b0;
		end else if (CLOCK_EN_IN) begin
			sbclk_ff      <= OUT_BIT_CLOCK_IN;
			sbclk_prev_ff <= sbclk_ff;
			swclk_ff      <= OUT_WORD_CLOCK_IN;
			swclk_prev_ff <= swclk_ff;
		end
	end

	assign OUT_BIT_CLOCK_OUT     = mbclk_ff;
	assign OUT_WORD_CLOCK_OUT    = mwclk_ff;
	assign OUT_BIT_CLOCK_OE_OUT  = PORT_MASTER_SELECT_IN;
	assign OUT_WORD_CLOCK_OE_OUT = PORT_MASTER_SELECT_IN;

	// ------------------------------------------------------------
	// Sample intake with one subframe of look-ahead for Z
	// ------------------------------------------------------------

	// A subframe is committed only when its successor arrives, so Z can mark the one before block start
	assign commit      = SAMPLE_VALID_IN && pend_vld_ff;
	assign commit_left = commit && !pend_right_ff;

	always_ff @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			pend_ff       <= sao_pkg::SUBFRAME_RST;
			pend_right_ff <= 1'b0;
			pend_vld_ff   <= 1'b0;
			hold_ff[0]    <= sao_pkg::SUBFRAME_RST;
			hold_ff[1]    <= sao_pkg::SUBFRAME_RST;
		end else if (CLOCK_EN_IN && SAMPLE_VALID_IN) begin
			pend_ff       <= '{data: SAMPLE_DATA_IN, v: SAMPLE_V_IN, u: SAMPLE_U_IN, c: SAMPLE_C_IN, z: 1'b0};
			pend_right_ff <= SAMPLE_RIGHT_IN;
			pend_vld_ff   <= 1'b1;
			if (pend_vld_ff) begin
				hold_ff[pend_right_ff]   <= pend_ff;
				hold_ff[pend_right_ff].z <= BLOCK_START_IN;
			end
		end
	end

	// Block start pin exists only without software control
	always_ff @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			blk_pin_ff <= 1'b0;
		end else if (CLOCK_EN_IN) begin
			blk_pin_ff <= HARDWARE_MODE_IN && SAMPLE_VALID_IN && BLOCK_START_IN;
		end
	end

	assign BLOCK_START_PIN_OUT = blk_pin_ff;

	// ------------------------------------------------------------
	// Serial shifter
	// ------------------------------------------------------------

	// Formatter sees the channel that the new half frame is about to carry
	always_comb begin
		fif.sub     = hold_ff[new_left ? 1'b0 : 1'b1];
		fif.res     = RESOLUTION_FIELD_IN;
		fif.justify = JUSTIFY_SELECT_IN;
		fif.half64  = BIT_CLOCK_RATE_SELECT_IN;
	end

	// Position counts bit cells from the word clock edge; the optional delay pushes data one cell back
	always_comb begin
		pos         = idx_ff + 7'h1 - {6'h0, FIRST_BIT_DELAY_IN};
		nxt_raw_bit = raw_bit_ff;
		if (half_start) begin
			nxt_raw_bit = FIRST_BIT_DELAY_IN ? 1'b0 : fif.word[63];
		end else if (inact_edge) begin
			nxt_raw_bit = ((idx_ff + 7'h1) >= {6'h0, FIRST_BIT_DELAY_IN}) && (pos <= sao_pkg::HALF_LAST_64)
				? word_ff[6'(sao_pkg::HALF_LAST_64 - pos)] : 1'b0;
		end
	end

	always_ff @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			idx_ff     <= 7'h0;
			word_ff    <= 64'h0;
			raw_bit_ff <= 1'b0;
		end else if (CLOCK_EN_IN) begin
			raw_bit_ff <= nxt_raw_bit;
			if (half_start) begin
				idx_ff  <= 7'h0;
				word_ff <= fif.word;
			end else if (inact_edge && idx_ff != sao_pkg::IDX_MAX) begin
				idx_ff <= idx_ff + 7'h1;
			end
		end
	end

	// Mute acts on the pin register every cycle, so it takes effect without waiting for a word edge
	always_ff @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			sdo_ff <= 1'b0;
		end else if (CLOCK_EN_IN) begin
			sdo_ff <= nxt_raw_bit && !OUTPUT_MUTE_BIT_IN;
		end
	end

	assign SERIAL_DATA_OUT = sdo_ff;

	// ------------------------------------------------------------
	// Slip detection in slave mode
	// ------------------------------------------------------------

	// Exactly one new left sample per frame is expected; none means a repeat, two or more a drop
	always_ff @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			left_cnt_ff <= 2'h0;
			slip_ff     <= 1'b0;
		end else if (CLOCK_EN_IN) begin
			if (half_start && new_left) begin
				left_cnt_ff <= commit_left ? 2'h1 : 2'h0;
			end else if (commit_left && left_cnt_ff != sao_pkg::SLIP_CNT_MAX) begin
				left_cnt_ff <= left_cnt_ff + 2'h1;
			end
			// Set wins over a clear arriving in the same cycle
			if (!PORT_MASTER_SELECT_IN && half_start && new_left && left_cnt_ff != 2'h1) begin
				slip_ff <= 1'b1;
			end else if (SLIP_CLEAR_IN) begin
				slip_ff <= 1'b0;
			end
		end
	end

	assign SAMPLE_SLIP_FLAG_OUT = slip_ff;

endmodule : serial_audio_output_port

// *** sao_asserts.sv ***
`timescale 1ns/10ps
module sao_asserts (
	input wire logic CLOCK_IN,
	input wire logic NRST_IN,
	input wire logic PORT_MASTER_SELECT_IN,
	input wire logic BIT_CLOCK_POLARITY_IN,
	input wire logic OUTPUT_MUTE_BIT_IN,
	input wire logic HARDWARE_MODE_IN,
	input wire logic SAMPLE_VALID_IN,
	input wire logic BLOCK_START_IN,
	input wire logic OUT_BIT_CLOCK_OUT,
	input wire logic OUT_BIT_CLOCK_OE_OUT,
	input wire logic OUT_WORD_CLOCK_OUT,
	input wire logic OUT_WORD_CLOCK_OE_OUT,
	input wire logic SERIAL_DATA_OUT,
	input wire logic SAMPLE_SLIP_FLAG_OUT,
	input wire logic BLOCK_START_PIN_OUT
);
	// ----
	// Port timing checks, one clock domain
	// ----
	default clocking cb @(posedge CLOCK_IN);
	endclocking
	default disable iff (!NRST_IN);

	// Pin drivers are on exactly in master mode
	property p_oe;
		OUT_BIT_CLOCK_OE_OUT == PORT_MASTER_SELECT_IN && OUT_WORD_CLOCK_OE_OUT == PORT_MASTER_SELECT_IN;
	endproperty
	a_oe: assert property (p_oe) else $error("clock pin enable wrong");
	// Master bit clock holds two cycles per level, also while muted
	property p_bclk;
		PORT_MASTER_SELECT_IN && $changed(OUT_BIT_CLOCK_OUT)
			|=> $stable(OUT_BIT_CLOCK_OUT) ##1 $changed(OUT_BIT_CLOCK_OUT);
	endproperty
	a_bclk: assert property (p_bclk) else $error("bit clock period wrong");
	// Word clock moves only with an inactive bit clock edge
	property p_wedge;
		PORT_MASTER_SELECT_IN && $changed(OUT_WORD_CLOCK_OUT)
			|-> $changed(OUT_BIT_CLOCK_OUT) && OUT_BIT_CLOCK_OUT == BIT_CLOCK_POLARITY_IN;
	endproperty
	a_wedge: assert property (p_wedge) else $error("word clock edge misplaced");
	// Data and bit clock leave the same register edge, so data moves only with an inactive edge; mute edges excluded
	property p_dedge;
		PORT_MASTER_SELECT_IN && $past(NRST_IN, 2) && !OUTPUT_MUTE_BIT_IN && !$past(OUTPUT_MUTE_BIT_IN)
			&& $changed(SERIAL_DATA_OUT)
			|-> $changed(OUT_BIT_CLOCK_OUT) && OUT_BIT_CLOCK_OUT == BIT_CLOCK_POLARITY_IN;
	endproperty
	a_dedge: assert property (p_dedge) else $error("data changed off the inactive edge");
	property p_mute; OUTPUT_MUTE_BIT_IN && $past(OUTPUT_MUTE_BIT_IN) |-> !SERIAL_DATA_OUT; endproperty
	a_mute: assert property (p_mute) else $error("data not silenced");
	property p_blk; HARDWARE_MODE_IN && SAMPLE_VALID_IN && BLOCK_START_IN |=> BLOCK_START_PIN_OUT; endproperty
	a_blk: assert property (p_blk) else $error("block pin missed");
	property p_blksrc;
		BLOCK_START_PIN_OUT |-> $past(HARDWARE_MODE_IN) && $past(SAMPLE_VALID_IN) && $past(BLOCK_START_IN);
	endproperty
	a_blksrc: assert property (p_blksrc) else $error("block pin without cause");
	// Slip detection is a slave-only feature
	property p_slip; $rose(SAMPLE_SLIP_FLAG_OUT) |-> !PORT_MASTER_SELECT_IN; endproperty
	a_slip: assert property (p_slip) else $error("slip flag in master mode");
	c_mute: cover property ($rose(OUTPUT_MUTE_BIT_IN));
	c_blk: cover property (BLOCK_START_PIN_OUT);
	c_slip: cover property ($rose(SAMPLE_SLIP_FLAG_OUT));
endmodule : sao_asserts

bind serial_audio_output_port sao_asserts i_sao_asserts (.*);

// *** audio_sink_model.sv ***
`timescale 1ns/10ps
module audio_sink_model (
	input  wire logic        clk_in,
	input  wire logic        pol_in,
	input  wire logic        gen_in,
	input  wire logic        bclk_in,
	input  wire logic        wclk_in,
	input  wire logic        sd_in,
	output logic             bclk_out,
	output logic             wclk_out,
	output logic             got_out,
	output logic [63:0]      word_out
);
	logic [63:0] sh;
	logic        bq;
	logic        wq;
	logic [7:0]  cnt;

	// Shift on the active edge; a new word clock level closes the half
	always_ff @(posedge clk_in) begin
		bq <= bclk_in;
		got_out <= 1'b0;
		if (bclk_in != bq && bclk_in != pol_in) begin
			wq <= wclk_in;
			sh <= {sh[62:0], sd_in};
			if (wclk_in != wq) begin
				got_out <= 1'b1;
				word_out <= sh;
				sh <= {63'h0, sd_in};
			end
		end
	end

	// Slave clocks: 64 cells a frame, word clock never stops, idle low when off
	always_ff @(posedge clk_in) begin
		cnt <= gen_in ? cnt + 8'h1 : 8'h0;
		if (!gen_in) begin
			bclk_out <= 1'b0;
			wclk_out <= 1'b0;
		end else begin
			if (cnt[1:0] == 2'h3) bclk_out <= ~bclk_out;
			if (cnt == 8'hff) wclk_out <= ~wclk_out;
		end
	end
endmodule : audio_sink_model

// *** tb_serial_audio_output_port.sv ***
`timescale 1ns/10ps
module tb_serial_audio_output_port;
	logic        CLOCK_IN = 1'b0, NRST_IN = 1'b0, CLOCK_EN_IN = 1'b1, PORT_MASTER_SELECT_IN = 1'b1;
	logic        BIT_CLOCK_RATE_SELECT_IN = 1'b0, JUSTIFY_SELECT_IN = 1'b0, FIRST_BIT_DELAY_IN = 1'b0;
	logic        BIT_CLOCK_POLARITY_IN = 1'b0, WORD_CLOCK_POLARITY_IN = 1'b0, OUTPUT_MUTE_BIT_IN = 1'b0;
	logic        HARDWARE_MODE_IN = 1'b0, SLIP_CLEAR_IN = 1'b0, SAMPLE_VALID_IN = 1'b0, SAMPLE_RIGHT_IN = 1'b0;
	logic        SAMPLE_V_IN = 1'b0, SAMPLE_U_IN = 1'b0, SAMPLE_C_IN = 1'b0, BLOCK_START_IN = 1'b0;
	logic [1:0]  RESOLUTION_FIELD_IN = 2'h0;
	logic [23:0] SAMPLE_DATA_IN = 24'h0;
	logic        OUT_BIT_CLOCK_IN, OUT_WORD_CLOCK_IN, OUT_BIT_CLOCK_OUT, OUT_BIT_CLOCK_OE_OUT, OUT_WORD_CLOCK_OUT;
	logic        OUT_WORD_CLOCK_OE_OUT, SERIAL_DATA_OUT, SAMPLE_SLIP_FLAG_OUT, BLOCK_START_PIN_OUT, got;
	logic        gen = 1'b0;
	logic [63:0] word;
	logic [63:0] q[$];
	int          failures = 0;
	int          n_tests = 0;
	// Config bits: rate, resolution, justify, delay, bit pol, word pol, mute
	logic [7:0]  cfgs [10] = '{8'h00, 8'h60, 8'h20, 8'h40, 8'h0a, 8'h10, 8'h04, 8'h80, 8'h62, 8'h01};

	serial_audio_output_port i_serial_audio_output_port (.*);
	audio_sink_model i_audio_sink_model (.clk_in(CLOCK_IN), .pol_in(BIT_CLOCK_POLARITY_IN), .gen_in(gen),
		.bclk_in(OUT_BIT_CLOCK_OUT), .wclk_in(OUT_WORD_CLOCK_OUT), .sd_in(SERIAL_DATA_OUT),
		.bclk_out(OUT_BIT_CLOCK_IN), .wclk_out(OUT_WORD_CLOCK_IN), .got_out(got), .word_out(word));

	always #2 CLOCK_IN = ~CLOCK_IN;

	task automatic complete_run();
		if (failures == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : complete_run

	task automatic cmp(input logic [63:0] g, input logic [63:0] e);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %0t got %h expected %h", $time, g, e);
		end
	endtask : cmp

	task automatic cmp_flag(input logic g, input logic e);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %0t flag %b expected %b", $time, g, e);
		end
	endtask : cmp_flag

	// This task sets the config under reset, so each run starts from clean hold registers
	task automatic rst(input logic [7:0] c, input logic m);
		@(posedge CLOCK_IN);
		NRST_IN <= 1'b0;
		PORT_MASTER_SELECT_IN <= m;
		gen <= !m;
		{BIT_CLOCK_RATE_SELECT_IN, RESOLUTION_FIELD_IN, JUSTIFY_SELECT_IN, FIRST_BIT_DELAY_IN,
			BIT_CLOCK_POLARITY_IN, WORD_CLOCK_POLARITY_IN, OUTPUT_MUTE_BIT_IN} <= c;
		repeat (6) @(posedge CLOCK_IN);
		NRST_IN <= 1'b1;
	endtask : rst

	task automatic send(input logic r, input logic [23:0] d, input logic [3:0] f);
		@(posedge CLOCK_IN);
		SAMPLE_VALID_IN <= 1'b1;
		{SAMPLE_RIGHT_IN, SAMPLE_DATA_IN, SAMPLE_V_IN, SAMPLE_U_IN, SAMPLE_C_IN, BLOCK_START_IN} <= {r, d, f};
	endtask : send

	// Expected cells of one half, msb first; f holds V, U, C and Z
	function automatic logic [63:0] ew(input logic [7:0] c, input logic [23:0] d, input logic [3:0] f);
		logic [31:0] w;
		w = c[6:5] == 2'h1 ? {d[23:4], 12'h0} : c[6:5] == 2'h2 ? {d[23:8], 16'h0} : {d, 8'h0};
		if (c[6:5] == 2'h3) w = {d, f, 4'h0};
		if (c[4]) w = {{8{d[23]}}, d};
		if (c[3]) w = w >> 1;
		ew = c[0] ? 64'h0 : c[7] ? {w, 32'h0} : {32'h0, w};
	endfunction : ew

	// Read on the falling edge so the sink's outputs have settled
	always @(negedge CLOCK_IN) begin
		if (got === 1'b1 && q.size() > 0) begin
			cmp(word, q.pop_front());
		end
	end

	// Ten formats take near 10k cycles; 300 us leaves a wide margin
	initial begin
		#300000;
		failures++;
		complete_run();
	end

	initial begin
		logic [23:0] a;
		logic [23:0] b;
		logic [2:0]  f;
		logic        blk;
		void'($urandom(32'h3d94));
		for (int i = 0; i < 10; i++) begin
			a = 24'($urandom);
			b = 24'($urandom);
			f = 3'($urandom);
			blk = i[0];
			rst(cfgs[i], 1'b1);
			HARDWARE_MODE_IN <= f[0];
			send(1'b0, a, {f, 1'b0});
			send(1'b1, b, {f, 1'b0});
			send(1'b0, ~a, {f, blk});
			@(posedge CLOCK_IN);
			SAMPLE_VALID_IN <= 1'b0;
			// Only the third subframe carries a block start, so the pin stands in this one cycle
			@(negedge CLOCK_IN);
			cmp_flag(BLOCK_START_PIN_OUT, f[0] && blk);
			repeat (600) @(posedge CLOCK_IN);
			for (int k = 0; k < 600 && (OUT_WORD_CLOCK_OUT ^ cfgs[i][1]) !== 1'b0; k++)
				@(posedge CLOCK_IN);
			for (int k = 0; k < 600 && (OUT_WORD_CLOCK_OUT ^ cfgs[i][1]) !== 1'b1; k++)
				@(posedge CLOCK_IN);
			repeat (8) @(posedge CLOCK_IN);
			q.push_back(ew(cfgs[i], a, {f, 1'b0}));
			q.push_back(ew(cfgs[i], b, {f, blk}));
			for (int k = 0; k < 1200 && q.size() > 0; k++)
				@(posedge CLOCK_IN);
			// A word that never arrived is a mismatch, and must not shift the next format's notes
			if (q.size() > 0) begin
				failures++;
				$display("CHECK FAILED %0t serial word missing", $time);
				q.delete();
			end
		end
		// Slave run, left-justified only, with no samples fed at all
		rst(8'h00, 1'b0);
		repeat (600) @(posedge CLOCK_IN);
		cmp_flag(SAMPLE_SLIP_FLAG_OUT, 1'b1);
		@(posedge OUT_WORD_CLOCK_IN);
		repeat (20) @(posedge CLOCK_IN);
		SLIP_CLEAR_IN <= 1'b1;
		@(posedge CLOCK_IN);
		SLIP_CLEAR_IN <= 1'b0;
		repeat (2) @(posedge CLOCK_IN);
		cmp_flag(SAMPLE_SLIP_FLAG_OUT, 1'b0);
		OUTPUT_MUTE_BIT_IN <= 1'b1;
		repeat (600) @(posedge CLOCK_IN);
		cmp_flag(SAMPLE_SLIP_FLAG_OUT, 1'b1);
		complete_run();
	end
endmodule : tb_serial_audio_output_port
